/* arith_pkg.sv */
// constants and types shared by the signed word arithmetic unit and its divider
// assumes one clock domain, core_clk, with the execution engine on the same clock
`default_nettype none

package arith_pkg;

  localparam int WORD_W     = 16;
  localparam int DIGIT_W    = 4;
  localparam int DIGIT_SEL_W = 2;
  localparam int DIV_CYCLES = 16;
  localparam int DIV_CNT_W  = 5;

  typedef logic [WORD_W-1:0]      word_t;
  typedef logic [DIGIT_SEL_W-1:0] digit_sel_t;

  localparam word_t WORD_RST = 16'h0000;

  // digit designation, encoded as digit count minus one
  localparam digit_sel_t DIG_ONE   = 2'h0;
  localparam digit_sel_t DIG_TWO   = 2'h1;
  localparam digit_sel_t DIG_THREE = 2'h2;
  localparam digit_sel_t DIG_FOUR  = 2'h3;

  localparam word_t MASK_ONE   = 16'h000F;
  localparam word_t MASK_TWO   = 16'h00FF;
  localparam word_t MASK_THREE = 16'h0FFF;
  localparam word_t MASK_FOUR  = 16'hFFFF;

  typedef enum logic [2:0] {
    OP_MOV,
    OP_ADD2,
    OP_ADD3,
    OP_SUB2,
    OP_SUB3,
    OP_MUL,
    OP_DIV
  } op_t;

  typedef enum logic {
    ST_IDLE,
    ST_DIV
  } state_t;

endpackage : arith_pkg

`default_nettype wire

/* div_if.sv */
// handshake between the arithmetic unit and its iterative divider
// assumes both ends run on core_clk
`default_nettype none

interface div_if;
  import arith_pkg::*;

  logic  start;
  word_t dividend;
  word_t divisor;
  logic  done;
  word_t quot;
  word_t rem;

  modport ctrl_side (output start, output dividend, output divisor,
                     input done, input quot, input rem);
  modport div_side  (input start, input dividend, input divisor,
                     output done, output quot, output rem);
endinterface : div_if

`default_nettype wire

/* div_core.sv */
// iterative signed 16-bit divider, one quotient bit per clock
// assumes divisor is nonzero when start is raised; caller filters zero
`default_nettype none

module div_core (
  input  wire logic core_clk,
  input  wire logic reset,
  div_if.div_side   dv
);
  import arith_pkg::*;

  logic                 busy_q;
  logic [DIV_CNT_W-1:0] cnt_q;
  word_t                quo_q;
  word_t                rem_q;
  word_t                dsr_q;
  logic                 neg_q_q;
  logic                 neg_r_q;
  logic                 done_q;

  // magnitudes of the operands
  wire word_t            mag_a     = dv.dividend[WORD_W-1] ? word_t'(-dv.dividend) : dv.dividend;
  wire word_t            mag_b     = dv.divisor[WORD_W-1]  ? word_t'(-dv.divisor)  : dv.divisor;
  wire logic [WORD_W:0]  shifted   = {rem_q, quo_q[WORD_W-1]};
  wire logic [WORD_W:0]  trial     = shifted - {1'b0, dsr_q};
  wire logic             fits      = ~trial[WORD_W];
  wire word_t            rem_next  = fits ? trial[WORD_W-1:0] : shifted[WORD_W-1:0];
  wire word_t            quo_next  = {quo_q[WORD_W-2:0], fits};
  wire logic             last      = (cnt_q == DIV_CNT_W'(DIV_CYCLES - 1));

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      busy_q  <= 1'b0;
      cnt_q   <= '0;
      quo_q   <= WORD_RST;
      rem_q   <= WORD_RST;
      dsr_q   <= WORD_RST;
      neg_q_q <= 1'b0;
      neg_r_q <= 1'b0;
      done_q  <= 1'b0;
    end else if (dv.start && !busy_q) begin
      busy_q  <= 1'b1;
      cnt_q   <= '0;
      quo_q   <= mag_a;
      rem_q   <= WORD_RST;
      dsr_q   <= mag_b;
      neg_q_q <= dv.dividend[WORD_W-1] ^ dv.divisor[WORD_W-1];
      neg_r_q <= dv.dividend[WORD_W-1];
      done_q  <= 1'b0;
    end else if (busy_q) begin
      quo_q  <= quo_next;
      rem_q  <= rem_next;
      cnt_q  <= cnt_q + DIV_CNT_W'(1);
      busy_q <= ~last;
      done_q <= last;
    end else begin
      done_q <= 1'b0;
    end
  end

  // sign fix-up: truncate toward zero, remainder follows dividend
  assign dv.done = done_q;
  assign dv.quot = neg_q_q ? word_t'(-quo_q) : quo_q;
  assign dv.rem  = neg_r_q ? word_t'(-rem_q) : rem_q;

endmodule : div_core

`default_nettype wire

/* signed_word_arith_unit.sv */
// signed 16-bit add, subtract, multiply, divide and word move for a sequence engine
// assumes the engine runs on core_clk and presents commands only while ready is high
`default_nettype none

module signed_word_arith_unit (
  input  wire logic                  core_clk,
  input  wire logic                  reset,
  // command condition, level
  input  wire logic                  cmd_on,
  input  wire arith_pkg::op_t        cmd_op,
  input  wire logic                  cmd_pulse,
  input  wire arith_pkg::word_t      src1,
  input  wire arith_pkg::word_t      src2,
  input  wire arith_pkg::word_t      dst_word,
  // destination description and latched error clear
  input  wire logic                  dst_is_bit,
  input  wire arith_pkg::digit_sel_t dst_digits,
  input  wire logic                  dst_is_index,
  input  wire logic                  err_clear,
  // answers
  output logic                       ready,
  output logic                       res_valid,
  output arith_pkg::word_t           res_lo,
  output arith_pkg::word_t           res_hi,
  output arith_pkg::word_t           res_lo_mask,
  output logic                       res_hi_write,
  output logic                       operation_error_flag,
  output logic                       operation_error_flag_latched
);
  import arith_pkg::*;

  div_if dv ();

  state_t state_q;
  state_t state_d;
  logic   cmd_on_q;

  // held context of a division in flight
  logic       div_bit_q;
  word_t      div_mask_q;

  // result registers hold between writes
  logic       res_valid_q;
  word_t      res_lo_q;
  word_t      res_lo_d;
  word_t      res_hi_q;
  word_t      res_hi_d;
  word_t      res_mask_q;
  word_t      res_mask_d;
  logic       res_hi_wr_q;
  logic       res_hi_wr_d;
  logic       err_q;
  logic       err_latch_q;

  //--------------------------------------------------------------------
  // command acceptance
  //--------------------------------------------------------------------
  wire logic idle      = (state_q == ST_IDLE);
  wire logic rise      = cmd_on & ~cmd_on_q;
  wire logic fire      = idle & cmd_on & (~cmd_pulse | rise);

  wire logic is_div    = (cmd_op == OP_DIV);
  wire logic div_zero  = is_div & (src2 == WORD_RST);
  wire logic op_error  = fire & (div_zero | dst_is_index);
  wire logic div_go    = fire & is_div & ~op_error;
  wire logic direct_go = fire & ~is_div & ~op_error;

  //--------------------------------------------------------------------
  // datapath
  //--------------------------------------------------------------------
  // in-place forms read the destination as the first operand
  wire word_t add_a    = (cmd_op == OP_ADD2) ? dst_word : src1;
  wire word_t add_b    = (cmd_op == OP_ADD2) ? src1 : src2;
  wire word_t sub_a    = (cmd_op == OP_SUB2) ? dst_word : src1;
  wire word_t sub_b    = (cmd_op == OP_SUB2) ? src1 : src2;

  // wrap to 16 bits, carry out discarded
  wire word_t sum      = word_t'(add_a + add_b);
  wire word_t diff     = word_t'(sub_a - sub_b);

  // signed product, sign lands in bit 31
  wire logic signed [2*WORD_W-1:0] prod = $signed(src1) * $signed(src2);
  wire word_t prod_lo  = prod[WORD_W-1:0];
  wire word_t prod_hi  = prod[2*WORD_W-1:WORD_W];

  // low digits that a bit-device destination accepts
  wire word_t digit_mask =
      (dst_digits == DIG_ONE)   ? MASK_ONE   :
      (dst_digits == DIG_TWO)   ? MASK_TWO   :
      (dst_digits == DIG_THREE) ? MASK_THREE : MASK_FOUR;
  wire word_t dst_mask = dst_is_bit ? digit_mask : MASK_FOUR;

  //--------------------------------------------------------------------
  // next result
  //--------------------------------------------------------------------
  always_comb begin
    res_lo_d    = res_lo_q;
    res_hi_d    = res_hi_q;
    res_mask_d  = res_mask_q;
    res_hi_wr_d = 1'b0;
    if (op_error) begin
      res_mask_d  = WORD_RST;
      res_hi_wr_d = 1'b0;
    end else if (direct_go) begin
      res_mask_d = dst_mask;
      case (cmd_op)
        OP_MOV: begin
          res_lo_d = src1;
        end
        OP_ADD2, OP_ADD3: begin
          res_lo_d = sum;
        end
        OP_SUB2, OP_SUB3: begin
          res_lo_d = diff;
        end
        OP_MUL: begin
          res_lo_d    = prod_lo;
          res_hi_d    = prod_hi;
          res_hi_wr_d = ~dst_is_bit;
        end
        default: begin
          res_lo_d = res_lo_q;
        end
      endcase
    end else if (dv.done) begin
      res_lo_d    = dv.quot;
      res_hi_d    = dv.rem;
      res_mask_d  = div_mask_q;
      res_hi_wr_d = ~div_bit_q;
    end
  end

  //--------------------------------------------------------------------
  // sequencing
  //--------------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (div_go) begin
          state_d = ST_DIV;
        end
      end
      ST_DIV: begin
        if (dv.done) begin
          state_d = ST_IDLE;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      state_q  <= ST_IDLE;
      cmd_on_q <= 1'b0;
    end else begin
      state_q  <= state_d;
      cmd_on_q <= cmd_on;
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      div_bit_q  <= 1'b0;
      div_mask_q <= MASK_FOUR;
    end else if (div_go) begin
      div_bit_q  <= dst_is_bit;
      div_mask_q <= dst_mask;
    end
  end

  // results change only when an operation completes or a command is rejected
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      res_valid_q <= 1'b0;
      res_lo_q    <= WORD_RST;
      res_hi_q    <= WORD_RST;
      res_mask_q  <= WORD_RST;
      res_hi_wr_q <= 1'b0;
      err_q       <= 1'b0;
    end else begin
      res_valid_q <= direct_go | op_error | dv.done;
      res_lo_q    <= res_lo_d;
      res_hi_q    <= res_hi_d;
      res_mask_q  <= res_mask_d;
      res_hi_wr_q <= res_hi_wr_d;
      err_q       <= op_error;
    end
  end

  // sticky copy; a new error wins over a clear in the same cycle
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      err_latch_q <= 1'b0;
    end else if (op_error) begin
      err_latch_q <= 1'b1;
    end else if (err_clear) begin
      err_latch_q <= 1'b0;
    end
  end

  //--------------------------------------------------------------------
  // divider
  //--------------------------------------------------------------------
  assign dv.start    = div_go;
  assign dv.dividend = src1;
  assign dv.divisor  = src2;

  div_core u_div (
    .core_clk (core_clk),
    .reset    (reset),
    .dv       (dv.div_side)
  );

  //--------------------------------------------------------------------
  // outputs
  //--------------------------------------------------------------------
  assign ready                        = idle;
  assign res_valid                    = res_valid_q;
  assign res_lo                       = res_lo_q;
  assign res_hi                       = res_hi_q;
  assign res_lo_mask                  = res_mask_q;
  assign res_hi_write                 = res_hi_wr_q;
  assign operation_error_flag         = err_q;
  assign operation_error_flag_latched = err_latch_q;

endmodule : signed_word_arith_unit

`default_nettype wire

/* swa_chk.sv */
// timing and value checks on the arithmetic unit's ports
// assumes binding to signed_word_arith_unit; timing checked for plain-form commands
`default_nettype none
module swa_chk (
  input wire logic                  core_clk,
  input wire logic                  reset,
  input wire logic                  cmd_on,
  input wire arith_pkg::op_t        cmd_op,
  input wire logic                  cmd_pulse,
  input wire arith_pkg::word_t      src1,
  input wire arith_pkg::word_t      src2,
  input wire logic                  dst_is_bit,
  input wire arith_pkg::digit_sel_t dst_digits,
  input wire logic                  dst_is_index,
  input wire logic                  ready,
  input wire logic                  res_valid,
  input wire arith_pkg::word_t      res_lo,
  input wire arith_pkg::word_t      res_hi,
  input wire arith_pkg::word_t      res_lo_mask,
  input wire logic                  res_hi_write,
  input wire logic                  operation_error_flag,
  input wire logic                  operation_error_flag_latched
);
  import arith_pkg::*;
  wire logic              tk   = cmd_on && ready && !cmd_pulse;
  wire logic              bad  = dst_is_index || (cmd_op == OP_DIV && src2 == WORD_RST);
  wire logic              ok   = tk && !bad && !dst_is_bit;
  wire word_t             sum  = src1 + src2;
  wire word_t             dif  = src1 - src2;
  wire logic signed [31:0] prod = $signed(src1) * $signed(src2);
  wire word_t             msk  = dst_digits == DIG_ONE ? MASK_ONE :
                                 dst_digits == DIG_TWO ? MASK_TWO :
                                 dst_digits == DIG_THREE ? MASK_THREE : MASK_FOUR;
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  a_add_wrap: assert property (ok && cmd_op == OP_ADD3 |=> res_valid && res_lo == $past(sum))
    else $error("sum mismatch");
  a_sub_wrap: assert property (ok && cmd_op == OP_SUB3 |=> res_lo == $past(dif))
    else $error("difference mismatch");
  a_mul_pair: assert property (ok && cmd_op == OP_MUL |=> {res_hi, res_lo} == $past(prod) && res_hi_write)
    else $error("product mismatch");
  a_div_time: assert property (ok && cmd_op == OP_DIV |=>
    (!ready && !res_valid)[*8] ##10 (res_valid && ready && res_hi_write))
    else $error("divide answer timing");
  a_bit_mask: assert property (tk && !bad && dst_is_bit && cmd_op != OP_DIV |=>
    res_lo_mask == $past(msk) && !res_hi_write) else $error("digit mask wrong");
  a_err_nowrite: assert property (tk && bad |=> res_valid && operation_error_flag &&
    res_lo_mask == WORD_RST && !res_hi_write) else $error("error answer wrong");
  a_err_sticky: assert property (operation_error_flag |-> operation_error_flag_latched)
    else $error("latched flag not set");
  a_res_hold: assert property (!res_valid |-> $stable(res_lo) && $stable(res_hi) &&
    $stable(res_lo_mask)) else $error("result changed without answer");
endmodule // swa_chk
`default_nettype wire

/* engine_model.sv */
// engine-side destination store written from the unit's answers
// assumes one clock and the unit's one-cycle answer pulse
`default_nettype none
module engine_model (
  input  wire logic             core_clk,
  input  wire logic             reset,
  input  wire logic             res_valid,
  input  wire arith_pkg::word_t res_lo,
  input  wire arith_pkg::word_t res_hi,
  input  wire arith_pkg::word_t res_lo_mask,
  input  wire logic             res_hi_write,
  output arith_pkg::word_t      dst_word,
  output arith_pkg::word_t      dst_hi
);
  import arith_pkg::*;
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      dst_word <= WORD_RST;
      dst_hi   <= WORD_RST;
    end else if (res_valid) begin
      dst_word <= (dst_word & ~res_lo_mask) | (res_lo & res_lo_mask);
      if (res_hi_write) dst_hi <= res_hi;
    end
  end
endmodule // engine_model
`default_nettype wire

/* tb.sv */
// self-checking bench for the arithmetic unit with a destination store
// assumes package, interface, divider, unit, checker and engine model compiled first
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  import arith_pkg::*;
  logic       core_clk, reset, cmd_on, cmd_pulse, dst_is_bit, dst_is_index, err_clear;
  logic       ready, res_valid, res_hi_write, operation_error_flag, operation_error_flag_latched;
  op_t        cmd_op;
  digit_sel_t dst_digits;
  word_t      src1, src2, dst_word, dst_hi, res_lo, res_hi, res_lo_mask, m_lo, m_hi, e_lo;
  logic       e_lat;
  logic [31:0] rng, x, y;
  int         error_cnt, checked;
  signed_word_arith_unit i_signed_word_arith_unit (.core_clk, .reset, .cmd_on, .cmd_op,
    .cmd_pulse, .src1, .src2, .dst_word, .dst_is_bit, .dst_digits, .dst_is_index, .err_clear,
    .ready, .res_valid, .res_lo, .res_hi, .res_lo_mask, .res_hi_write, .operation_error_flag,
    .operation_error_flag_latched);
  engine_model i_engine_model (.core_clk, .reset, .res_valid, .res_lo, .res_hi, .res_lo_mask,
    .res_hi_write, .dst_word, .dst_hi);
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  function automatic logic [31:0] nxt();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction
  task automatic chk(string n, logic [31:0] e, logic [31:0] s);
    checked++;
    if (e !== s) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic run(op_t op, int a, int b, logic bt, digit_sel_t dg, logic ix);
    int r, h, n;
    word_t m;
    logic er, hw;
    er = ix || (op == OP_DIV && b == 0);
    r = 0;
    h = 0;
    case (op)
      OP_MOV:  r = a;
      OP_ADD2: r = $signed(m_lo) + a;
      OP_ADD3: r = a + b;
      OP_SUB2: r = $signed(m_lo) - a;
      OP_SUB3: r = a - b;
      OP_MUL:  begin r = a * b; h = r >>> 16; end
      default: if (!er) begin r = a / b; h = a % b; end
    endcase
    m = er ? 16'h0000 : bt ? word_t'((1 << (4 * dg + 4)) - 1) : 16'hFFFF;
    hw = !er && !bt && (op == OP_MUL || op == OP_DIV);
    @(posedge core_clk); #1;
    {cmd_on, cmd_pulse, src1, src2} = {2'b10, a[15:0], b[15:0]};
    cmd_op = op;
    {dst_is_bit, dst_digits, dst_is_index} = {bt, dg, ix};
    @(posedge core_clk); #1;
    cmd_on = 1'b0;
    n = 0;
    while (res_valid !== 1'b1 && n < 30) begin
      @(posedge core_clk); #1;
      n++;
    end
    if (!er) e_lo = r[15:0];
    e_lat |= er;
    chk("valid", 1, res_valid);
    chk("lo", e_lo, res_lo);
    chk("mask", m, res_lo_mask);
    chk("hi_write", hw, res_hi_write);
    chk("error", er, operation_error_flag);
    if (hw) chk("hi", h[15:0], res_hi);
    m_lo = (m_lo & ~m) | (word_t'(r) & m);
    if (hw) m_hi = h[15:0];
    @(posedge core_clk); #1;
    chk("dest", {m_hi, m_lo}, {dst_hi, dst_word});
    chk("latched", e_lat, operation_error_flag_latched);
  endtask
  task automatic hold(logic p, int e);
    int n;
    n = 0;
    @(posedge core_clk); #1;
    {cmd_on, cmd_pulse, src1, src2, dst_is_bit, dst_is_index} = {1'b1, p,
      16'h0001, 16'h0002, 2'b00};
    cmd_op = OP_ADD3;
    repeat (3) begin @(posedge core_clk); #1; n += res_valid; end
    cmd_on = 1'b0;
    repeat (3) begin @(posedge core_clk); #1; n += res_valid; end
    chk("count", e, n);
    m_lo = 16'h0003;
    e_lo = 16'h0003;
  endtask
  task automatic final_report;
    $display("mismatches %0d comparisons %0d", error_cnt, checked);
    if (error_cnt == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    #100000;
    error_cnt++;
    final_report();
  end
  initial begin
    {rng, error_cnt, checked, reset, err_clear} = {32'hE604, 64'h0, 2'b10};
    {cmd_on, cmd_pulse, src1, src2, dst_is_bit, dst_digits, dst_is_index} = '0;
    cmd_op = OP_MOV;
    {m_lo, m_hi, e_lo, e_lat} = '0;
    repeat (12) @(posedge core_clk);
    #1 reset = 1'b0;
    run(OP_ADD3, 32767, 1, 0, DIG_FOUR, 0);
    run(OP_SUB3, -32768, 1, 0, DIG_FOUR, 0);
    run(OP_SUB3, 5, 8, 0, DIG_FOUR, 0);
    run(OP_MOV, 100, 0, 0, DIG_FOUR, 0);
    run(OP_ADD2, 7, 0, 0, DIG_FOUR, 0);
    run(OP_SUB2, 200, 0, 0, DIG_FOUR, 0);
    run(OP_MUL, 5678, 1234, 0, DIG_FOUR, 0);
    run(OP_MUL, -5, 3, 1, DIG_ONE, 0);
    run(OP_DIV, -5, 3, 0, DIG_FOUR, 0);
    run(OP_DIV, 5, -3, 0, DIG_FOUR, 0);
    run(OP_DIV, -5, -3, 0, DIG_FOUR, 0);
    run(OP_DIV, -32768, -1, 0, DIG_FOUR, 0);
    run(OP_DIV, -700, 3, 1, DIG_TWO, 0);
    run(OP_DIV, 9, 0, 0, DIG_FOUR, 0);
    run(OP_ADD3, 1, 1, 0, DIG_FOUR, 1);
    @(posedge core_clk); #1 err_clear = 1'b1;
    @(posedge core_clk); #1 err_clear = 1'b0;
    e_lat = 1'b0;
    chk("cleared", 0, operation_error_flag_latched);
    hold(0, 3);
    hold(1, 1);
    repeat (60) begin
      x = nxt();
      y = nxt();
      run(op_t'(y[2:0] % 7), $signed(x[15:0]), $signed(x[31:16]), y[3], y[5:4], y[9:6] == 0);
    end
    reset = 1'b1;
    @(posedge core_clk); #1 reset = 1'b0;
    {m_lo, m_hi, e_lo, e_lat} = '0;
    run(OP_MUL, -5, -3, 0, DIG_FOUR, 0);
    final_report();
  end
endmodule // tb
bind signed_word_arith_unit swa_chk i_swa_chk (.core_clk, .reset, .cmd_on, .cmd_op, .cmd_pulse,
  .src1, .src2, .dst_is_bit, .dst_digits, .dst_is_index, .ready, .res_valid, .res_lo, .res_hi,
  .res_lo_mask, .res_hi_write, .operation_error_flag, .operation_error_flag_latched);
`default_nettype wire
